// [core/pmc_counter.v]
`timescale 1ns/1ps
`default_nettype none
`include "pmc_defs.vh"

module pmc_counter #(
   parameter [0:0] ASYNC_CLEAR = `PMC_CLEAR_DEFAULT
) (
   input wire ref_clk_i,
   input wire srst_i,
   input wire async_master_clear_n_i,
   input wire sync_clear_n_i,
   input wire load_enable_n_i,
   input wire count_enable_parallel_i,
   input wire count_enable_trickle_i,
   input wire [`PMC_WIDTH-1:0] preset_data_in_i,
   output reg [`PMC_WIDTH-1:0] count_state_out_o,
   output wire terminal_count_out_o
);

   // ----------------------------------------
   // Mode codes
   // ----------------------------------------
   localparam [1:0] MODE_CLEAR = 2'b00;
   localparam [1:0] MODE_LOAD = 2'b01;
   localparam [1:0] MODE_COUNT = 2'b10;
   localparam [1:0] MODE_HOLD = 2'b11;

   // ----------------------------------------
   // Mode decode function
   // ----------------------------------------
   // clear, then load, then count, then hold
   function [1:0] pmc_pick_mode;
      input clear_req_in;
      input load_n_in;
      input cnt_par_in;
      input cnt_trk_in;
      begin
         if (clear_req_in) begin
            pmc_pick_mode = MODE_CLEAR;
         end else if (!load_n_in) begin
            pmc_pick_mode = MODE_LOAD;
         end else if (cnt_par_in && cnt_trk_in) begin
            pmc_pick_mode = MODE_COUNT;
         end else begin
            pmc_pick_mode = MODE_HOLD;
         end
      end
   endfunction

   // ----------------------------------------
   // All-ones decode function
   // ----------------------------------------
   function pmc_is_top;
      input [`PMC_WIDTH-1:0] value;
      begin
         pmc_is_top = (value == `PMC_ALL_ONES);
      end
   endfunction

   // ----------------------------------------
   // Clear request per build
   // ----------------------------------------
   reg clear_req;

   // only the sync build listens to the clear pin here
   always @* begin
      clear_req = srst_i;
      if (!ASYNC_CLEAR) begin
         // low clear pin wins at the edge
         if (!sync_clear_n_i) begin
            clear_req = 1'b1;
         end
      end
   end

   // ----------------------------------------
   // Mode selection
   // ----------------------------------------
   reg [1:0] mode;

   always @* begin
      mode = pmc_pick_mode(clear_req, load_enable_n_i, count_enable_parallel_i,
         count_enable_trickle_i);
   end

   // ----------------------------------------
   // Per-bit toggle enables
   // ----------------------------------------
   // Carry look-ahead: bit n flips when all lower bits are one
   wire [`PMC_WIDTH-1:0] toggle_en;
   genvar bit_idx;

   assign toggle_en[0] = 1'b1;

   generate
      for (bit_idx = 1; bit_idx < `PMC_WIDTH; bit_idx = bit_idx + 1) begin : g_toggle
         assign toggle_en[bit_idx] = &count_state_out_o[bit_idx-1:0];
      end
   endgenerate

   // ----------------------------------------
   // Next-state selection
   // ----------------------------------------
   reg [`PMC_WIDTH-1:0] next_state;

   always @* begin
      next_state = count_state_out_o;
      case (mode)
         MODE_CLEAR: begin
            next_state = `PMC_ZERO;
         end
         MODE_LOAD: begin
            next_state = preset_data_in_i;
         end
         MODE_COUNT: begin
            // all ones flips every bit, so 15 rolls to 0
            next_state = count_state_out_o ^ toggle_en;
         end
         MODE_HOLD: begin
            next_state = count_state_out_o;
         end
         default: begin
            next_state = count_state_out_o;
         end
      endcase
   end

   // ----------------------------------------
   // State register, clear style per build
   // ----------------------------------------
   generate
      if (ASYNC_CLEAR) begin : g_async
         // clear pin acts without the clock
         always @(posedge ref_clk_i or negedge async_master_clear_n_i) begin
            if (!async_master_clear_n_i) begin
               count_state_out_o <= `PMC_ZERO;
            end else begin
               count_state_out_o <= next_state;
            end
         end
      end else begin : g_sync
         // controls sampled at the edge only
         always @(posedge ref_clk_i) begin
            count_state_out_o <= next_state;
         end
      end
   endgenerate

   // ----------------------------------------
   // Terminal count
   // ----------------------------------------
   // combinational so cascades see trickle at once
   // may glitch, so never a clock or reset downstream
   assign terminal_count_out_o = pmc_is_top(count_state_out_o) && count_enable_trickle_i;

endmodule // pmc_counter

`default_nettype wire

// [core/pmc_defs.vh]
`ifndef PMC_DEFS_VH
`define PMC_DEFS_VH

// ----------------------------------------
// Counter shape
// ----------------------------------------
`define PMC_WIDTH 4
`define PMC_ZERO 4'h0
`define PMC_ONE 4'h1
`define PMC_ALL_ONES 4'hf

// ----------------------------------------
// Clear style selection
// ----------------------------------------
`define PMC_CLEAR_SYNC 1'b0
`define PMC_CLEAR_ASYNC 1'b1
`define PMC_CLEAR_DEFAULT 1'b0

`endif

// [verif/pmc_chk.sv]
`timescale 1ns/1ps
`default_nettype none
module pmc_chk(input wire logic ref_clk_i,srst_i,sync_clear_n_i,load_enable_n_i,
count_enable_parallel_i,count_enable_trickle_i,terminal_count_out_o,
input wire logic [3:0] preset_data_in_i,count_state_out_o);
wire [3:0] q=count_state_out_o;
wire s=sync_clear_n_i,l=load_enable_n_i,t=count_enable_trickle_i,e=count_enable_parallel_i;
default clocking @(posedge ref_clk_i);endclocking
default disable iff(srst_i);
sequence cnt;s&l&e&t;endsequence
a_clr_wins:assert property(!s|=>q==4'h0)else $error("clr");
a_load_copy:assert property(s&!l|=>q==$past(preset_data_in_i))else $error("ld");
a_cnt_step:assert property(cnt|=>q==$past(q)+4'h1)else $error("cnt");
a_wrap_zero:assert property(cnt##0 q==4'hf|=>q==4'h0)else $error("wrap");
a_hold_par:assert property(s&l&!e|=>$stable(q))else $error("hold");
a_hold_trk:assert property(s&l&!t|=>$stable(q))else $error("hold");
a_tc_dec:assert property(terminal_count_out_o==(&q&t))else $error("tc");
a_srst_clr:assert property(disable iff(1'b0)srst_i|=>q==4'h0)else $error("rst");
endmodule // pmc_chk
bind pmc_counter pmc_chk u_chk(.*);
`default_nettype wire

// [verif/pmc_ctl.sv]
`timescale 1ns/1ps
`default_nettype none
module pmc_ctl(input wire logic ref_clk_i,output logic [7:0] ctl_o=8'h0);
logic [13:0] r;
initial begin
r=$urandom(1782);
forever @(negedge ref_clk_i) begin
r=$urandom;
ctl_o<={|r[2:0],|r[5:3],|r[7:6],|r[9:8],r[13:10]};
end
end
endmodule // pmc_ctl
`default_nettype wire

// [verif/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
logic ref_clk_i=1,srst_i=1,tc;
logic [7:0] c;
logic [3:0] q,m;
int err_count,cmp_count;
always #20 ref_clk_i=~ref_clk_i;
pmc_ctl u_pmc_ctl(.ref_clk_i,.ctl_o(c));
pmc_counter u_pmc_counter(.ref_clk_i,.srst_i,.async_master_clear_n_i(1'b1),.sync_clear_n_i(c[7]),
.load_enable_n_i(c[6]),.count_enable_parallel_i(c[5]),.count_enable_trickle_i(c[4]),
.preset_data_in_i(c[3:0]),.count_state_out_o(q),.terminal_count_out_o(tc));
task tally_and_finish;
if(err_count==0&&cmp_count>0)$display("RESULT: PASS");
else $display("RESULT: FAIL");
$finish;
endtask
always @(posedge ref_clk_i) begin
m=srst_i|!c[7]?4'h0:!c[6]?c[3:0]:c[5]&c[4]?m+4'h1:m;
#1 cmp_count++;
if(q!==m)begin
err_count++;
$display("[FAIL] %0t %h %h",$time,q,m);
end
cmp_count++;
if(tc!==(m==4'hf&&c[4]))begin
err_count++;
$display("[FAIL] %0t %h %h",$time,tc,(m==4'hf&&c[4]));
end
end
initial begin
#100 srst_i=0;
#80000 tally_and_finish;
end
initial begin #90000 err_count++;tally_and_finish;end
endmodule // tb_top
`default_nettype wire
